// >>> det_pkg.sv
package det_pkg;

    localparam int unsigned NCH = 2;
    localparam int unsigned AXI_AW = 8;
    localparam int unsigned PSC_W = 7;

    // register indexes; byte address is four times the index
    localparam logic [5:0] IDX_CNT0_DATA = 6'h0D;
    localparam logic [5:0] IDX_CNT0_CTRL = 6'h0E;
    localparam logic [5:0] IDX_CNT1_DATA = 6'h10;
    localparam logic [5:0] IDX_CNT1_CTRL = 6'h11;
    localparam logic [5:0] IDX_STATUS = 6'h12;

    localparam logic [7:0] CTRL_RST = 8'h08;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CTRL_MASK0 = 8'hDF;
    localparam logic [7:0] CTRL_MASK1 = 8'hD8;
    localparam logic [2:0] CNT1_DIV_CODE = 3'h2;

    localparam int unsigned CTRL_DIV_LSB = 0;
    localparam int unsigned CTRL_EDGE_BIT = 3;
    localparam int unsigned CTRL_RUN_BIT = 4;
    localparam int unsigned CTRL_MODE_LSB = 6;
    localparam int unsigned STAT_FLAG0_BIT = 0;
    localparam int unsigned STAT_FLAG1_BIT = 1;

    localparam logic [1:0] MODE_UNUSED = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_PULSE = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] mode;
        logic rsv;
        logic run;
        logic edge_sel;
        logic [2:0] div_sel;
    } det_ctrl_t;

    typedef enum logic {
        PW_IDLE,
        PW_MEAS
    } det_pw_t;

endpackage : det_pkg

// >>> det_timer_counter.sv
`timescale 1ns/1ps
module det_timer_counter
    import det_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NCH-1:0] event_pin,
    output logic cnt0_overflow_flag,
    output logic cnt1_overflow_flag
);

    logic aw_held_r;
    logic aw_held_nxt;
    logic [5:0] wr_idx_r;
    logic [5:0] wr_idx_nxt;
    logic w_held_r;
    logic w_held_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic wlane_r;
    logic wlane_nxt;
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_go;
    logic wr_byte;
    logic wr_mapped;
    logic st_clr0;
    logic st_clr1;
    logic [5:0] rd_idx;
    logic [7:0] cnt_val [NCH];
    logic [7:0] ctrl_val [NCH];
    logic [NCH-1:0] flag_val;

    // write address and data are held separately, so they may come in either order
    always_comb
    begin
        aw_take = s_axi_awvalid & awready_r;
        w_take = s_axi_wvalid & wready_r;
        ar_take = s_axi_arvalid & arready_r;
        wr_go = aw_held_r & w_held_r & ~bvalid_r;
        wr_byte = wr_go & wlane_r;
        wr_mapped = (wr_idx_r == IDX_CNT0_DATA) | (wr_idx_r == IDX_CNT0_CTRL) | (wr_idx_r == IDX_CNT1_DATA)
            | (wr_idx_r == IDX_CNT1_CTRL) | (wr_idx_r == IDX_STATUS);
        st_clr0 = wr_byte & (wr_idx_r == IDX_STATUS) & wdata_r[STAT_FLAG0_BIT];
        st_clr1 = wr_byte & (wr_idx_r == IDX_STATUS) & wdata_r[STAT_FLAG1_BIT];
        aw_held_nxt = aw_held_r;
        wr_idx_nxt = wr_idx_r;
        w_held_nxt = w_held_r;
        wdata_nxt = wdata_r;
        wlane_nxt = wlane_r;
        if (aw_take)
        begin
            aw_held_nxt = 1'b1;
            wr_idx_nxt = s_axi_awaddr[AXI_AW-1:2];
        end
        else if (wr_go)
        begin
            aw_held_nxt = 1'b0;
        end
        if (w_take)
        begin
            w_held_nxt = 1'b1;
            wdata_nxt = s_axi_wdata[7:0];
            wlane_nxt = s_axi_wstrb[0];
        end
        else if (wr_go)
        begin
            w_held_nxt = 1'b0;
        end
        awready_nxt = ~aw_held_nxt;
        wready_nxt = ~w_held_nxt;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (wr_go)
        begin
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_r & s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
    end

    // read answers one cycle after the address is taken
    always_comb
    begin
        rd_idx = s_axi_araddr[AXI_AW-1:2];
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (ar_take)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            case (rd_idx)
                IDX_CNT0_DATA: rdata_nxt = {24'h000000, cnt_val[0]};
                IDX_CNT0_CTRL: rdata_nxt = {24'h000000, ctrl_val[0] & CTRL_MASK0};
                IDX_CNT1_DATA: rdata_nxt = {24'h000000, cnt_val[1]};
                IDX_CNT1_CTRL: rdata_nxt = {24'h000000, ctrl_val[1] & CTRL_MASK1};
                IDX_STATUS: rdata_nxt = {30'h00000000, flag_val};
                default:
                begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_r & s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
        arready_nxt = ~rvalid_nxt;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            wr_idx_r <= 6'h00;
            w_held_r <= 1'b0;
            wdata_r <= 8'h00;
            wlane_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end
        else
        begin
            aw_held_r <= aw_held_nxt;
            wr_idx_r <= wr_idx_nxt;
            w_held_r <= w_held_nxt;
            wdata_r <= wdata_nxt;
            wlane_r <= wlane_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    generate
        for (genvar g = 0; g < NCH; g++)
        begin : g_ch
            localparam logic [5:0] DATA_IDX = (g == 0) ? IDX_CNT0_DATA : IDX_CNT1_DATA;
            localparam logic [5:0] CTRL_IDX = (g == 0) ? IDX_CNT0_CTRL : IDX_CNT1_CTRL;
            localparam logic [7:0] CMASK = (g == 0) ? CTRL_MASK0 : CTRL_MASK1;
            det_ctrl_t ctrl_r;
            det_ctrl_t ctrl_nxt;
            logic [7:0] cnt_r;
            logic [7:0] cnt_nxt;
            logic [7:0] pre_r;
            logic [7:0] pre_nxt;
            logic [PSC_W-1:0] psc_r;
            logic [PSC_W-1:0] psc_nxt;
            det_pw_t pw_r;
            det_pw_t pw_nxt;
            logic flag_r;
            logic flag_nxt;
            logic pin_s1_r;
            logic pin_s2_r;
            logic pin_d_r;
            logic rise;
            logic fall;
            logic [2:0] div;
            logic [PSC_W-1:0] psc_mask;
            logic tick;
            logic inc;
            logic wrap;
            logic done;
            logic clr;

            always_comb
            begin
                rise = pin_s2_r & ~pin_d_r;
                fall = ~pin_s2_r & pin_d_r;
                div = (g == 0) ? ctrl_r.div_sel : CNT1_DIV_CODE;
                psc_mask = PSC_W'((8'h01 << div) - 8'h01);
                tick = ((psc_r & psc_mask) == psc_mask);
                psc_nxt = psc_r + PSC_W'(1);
                done = 1'b0;
                // counting gated by run bit and mode, unused mode holds
                case (ctrl_r.mode)
                    MODE_EVENT: inc = ctrl_r.run & (ctrl_r.edge_sel ? fall : rise);
                    MODE_TIMER: inc = ctrl_r.run & tick;
                    MODE_PULSE: inc = ctrl_r.run & (pw_r == PW_MEAS) & tick;
                    default: inc = 1'b0;
                endcase
                pw_nxt = PW_IDLE;
                if (ctrl_r.run && ctrl_r.mode == MODE_PULSE)
                begin
                    case (pw_r)
                        PW_IDLE: pw_nxt = (ctrl_r.edge_sel ? rise : fall) ? PW_MEAS : PW_IDLE;
                        PW_MEAS:
                        begin
                            done = ctrl_r.edge_sel ? fall : rise;
                            pw_nxt = done ? PW_IDLE : PW_MEAS;
                        end
                        default: pw_nxt = PW_IDLE;
                    endcase
                end
                wrap = inc & (cnt_r == CNT_MAX);
                cnt_nxt = cnt_r;
                if (inc)
                begin
                    cnt_nxt = wrap ? pre_r : cnt_r + 8'h01;
                end
                pre_nxt = pre_r;
                if (wr_byte && wr_idx_r == DATA_IDX)
                begin
                    pre_nxt = wdata_r;
                    if (!ctrl_r.run)
                    begin
                        cnt_nxt = wdata_r;
                    end
                end
                ctrl_nxt = ctrl_r;
                if (done)
                begin
                    ctrl_nxt.run = 1'b0;
                end
                if (wr_byte && wr_idx_r == CTRL_IDX)
                begin
                    ctrl_nxt = det_ctrl_t'(wdata_r & CMASK);
                end
                clr = (g == 0) ? st_clr0 : st_clr1;
                flag_nxt = wrap | (flag_r & ~clr);
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    ctrl_r <= det_ctrl_t'(CTRL_RST & CMASK);
                    cnt_r <= CNT_RST;
                    pre_r <= CNT_RST;
                    psc_r <= '0;
                    pw_r <= PW_IDLE;
                    flag_r <= 1'b0;
                    pin_s1_r <= 1'b0;
                    pin_s2_r <= 1'b0;
                    pin_d_r <= 1'b0;
                end
                else
                begin
                    ctrl_r <= ctrl_nxt;
                    cnt_r <= cnt_nxt;
                    pre_r <= pre_nxt;
                    psc_r <= psc_nxt;
                    pw_r <= pw_nxt;
                    flag_r <= flag_nxt;
                    pin_s1_r <= event_pin[g];
                    pin_s2_r <= pin_s1_r;
                    pin_d_r <= pin_s2_r;
                end
            end

            assign cnt_val[g] = cnt_r;
            assign ctrl_val[g] = ctrl_r;
            assign flag_val[g] = flag_r;
        end
    endgenerate

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign cnt0_overflow_flag = flag_val[0];
    assign cnt1_overflow_flag = flag_val[1];

endmodule : det_timer_counter

// >>> det_timer_counter_chk.sv
`timescale 1ns/1ps
module det_timer_counter_chk
    import det_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NCH-1:0] event_pin,
    input wire logic cnt0_overflow_flag,
    input wire logic cnt1_overflow_flag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before ready");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before ready");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after address");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer not two cycles after take");
    AST_RD_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above low byte not zero");
    AST_RD_ERR: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    AST_F0_CLR: assert property ($fell(cnt0_overflow_flag) |-> $rose(s_axi_bvalid))
        else $error("counter 0 flag cleared without a write");
    AST_F1_CLR: assert property ($fell(cnt1_overflow_flag) |-> $rose(s_axi_bvalid))
        else $error("counter 1 flag cleared without a write");
endmodule : det_timer_counter_chk

// >>> det_evt_model.sv
`timescale 1ns/1ps
module det_evt_model
(
    input wire logic aclk,
    input wire logic [1:0] want,
    output logic [1:0] event_pin
);
    // each pin follows its request after a random lag of zero to two cycles
    int dly [2] = '{0, 0};
    initial event_pin = 2'h0;
    always @(posedge aclk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (event_pin[i] !== want[i])
            begin
                if (dly[i] == 0)
                begin
                    event_pin[i] <= want[i];
                    dly[i] <= $urandom_range(2);
                end
                else
                    dly[i] <= dly[i] - 1;
            end
        end
    end
endmodule : det_evt_model

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    import det_pkg::*;
    typedef struct packed {logic [7:0] lo; logic [7:0] hi; logic [1:0] resp;} det_note_t;
    localparam logic [7:0] AD0 = {IDX_CNT0_DATA, 2'h0};
    localparam logic [7:0] AC0 = {IDX_CNT0_CTRL, 2'h0};
    localparam logic [7:0] AD1 = {IDX_CNT1_DATA, 2'h0};
    localparam logic [7:0] AC1 = {IDX_CNT1_CTRL, 2'h0};
    localparam logic [7:0] AST = {IDX_STATUS, 2'h0};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, p, lo, hi;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [1:0] want = 2'h0;
    logic [1:0] pin, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, f0, f1;
    logic [31:0] rdata;
    int fails = 0, samples_checked = 0;
    det_note_t notes [$];
    det_note_t nt;
    always #25 aclk = ~aclk;
    det_evt_model pm (.aclk(aclk), .want(want), .event_pin(pin));
    det_timer_counter DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_pin(pin),
        .cnt0_overflow_flag(f0), .cnt1_overflow_flag(f1));
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
        notes.push_back('{8'h0, 8'h0, r});
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] l, input logic [7:0] h, input logic [1:0] r);
        notes.push_back('{l, h, r});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd
    task automatic drive_pin(input int ch, input logic v, input int n);
        @(posedge aclk);
        want[ch] <= v;
        repeat (n) @(posedge aclk);
    endtask : drive_pin
    task automatic end_sim();
        $display("checked %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    always @(posedge aclk)
    begin
        if ((bvalid && bready) || (rvalid && rready))
        begin
            nt = notes.pop_front();
            chk(!(bvalid && bready) || bresp === nt.resp, "write response");
            chk(!(rvalid && rready) || (rresp === nt.resp && rdata[7:0] >= nt.lo && rdata[7:0] <= nt.hi), "read data");
        end
    end
    initial
    begin
        repeat (30000) @(posedge aclk);
        chk(1'b0, "watchdog expired");
        end_sim();
    end
    initial
    begin
        void'($urandom(32'h42b2d6b2));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(AC0, CTRL_RST, CTRL_RST, RESP_OKAY);
        rd(AC1, CTRL_RST, CTRL_RST, RESP_OKAY);
        rd(AD0, CNT_RST, CNT_RST, RESP_OKAY);
        rd(8'h00, 8'h0, 8'h0, RESP_SLVERR);
        wr(8'h00, 8'h55, RESP_SLVERR);
        wr(AC1, 8'h37, RESP_OKAY);
        rd(AC1, 8'h10, 8'h10, RESP_OKAY);
        wr(AC0, 8'h37, RESP_OKAY);
        rd(AC0, 8'h17, 8'h17, RESP_OKAY);
        for (int i = 0; i < 4; i++) drive_pin(i / 2, !i[0], 10);
        rd(AD0, 8'h0, 8'h0, RESP_OKAY);
        rd(AD1, 8'h0, 8'h0, RESP_OKAY);
        $display("test unused bits and mode 00 done");
        // stop both counters so the next data writes load the counters as well as the preloads
        wr(AC0, 8'h00, RESP_OKAY);
        wr(AC1, 8'h00, RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            p = 8'($urandom_range(32'hF0));
            wr(i[1] ? AD1 : AD0, p, RESP_OKAY);
            wr(i[1] ? AC1 : AC0, {MODE_EVENT, 2'h1, i[0], 3'h0}, RESP_OKAY);
            for (int k = 0; k < 5; k++) drive_pin(i[1], !k[0], 10);
            wr(i[1] ? AC1 : AC0, {MODE_EVENT, 2'h0, i[0], 3'h0}, RESP_OKAY);
            drive_pin(i[1], 1'b0, 10);
            rd(i[1] ? AD1 : AD0, p + 8'h3 - i[0], p + 8'h3 - i[0], RESP_OKAY);
        end
        $display("test event count done");
        wr(AD0, 8'hFE, RESP_OKAY);
        wr(AC0, 8'h50, RESP_OKAY);
        wr(AD0, 8'h10, RESP_OKAY);
        for (int k = 0; k < 3; k++) drive_pin(0, !k[0], 10);
        chk(f0 === 1'b1 && f1 === 1'b0, "overflow flag");
        wr(AC0, 8'h40, RESP_OKAY);
        drive_pin(0, 1'b0, 10);
        rd(AD0, 8'h10, 8'h10, RESP_OKAY);
        rd(AST, 8'h01, 8'h01, RESP_OKAY);
        wr(AST, 8'h01, RESP_OKAY);
        chk(f0 === 1'b0, "flag clear");
        $display("test overflow done");
        for (int d = 0; d < 8; d++)
        begin
            lo = (8'hC8 >> d) - 8'h1;
            hi = (8'hD8 >> d) + 8'h1;
            wr(AD0, 8'h0, RESP_OKAY);
            wr(AC0, {MODE_TIMER, 3'h2, 3'(d)}, RESP_OKAY);
            repeat (200) @(posedge aclk);
            wr(AC0, {MODE_TIMER, 3'h0, 3'(d)}, RESP_OKAY);
            rd(AD0, lo, hi, RESP_OKAY);
        end
        $display("test prescaler done");
        for (int e = 0; e < 2; e++)
        begin
            p = e ? 8'hA : 8'h14;
            wr(AD1, 8'h0, RESP_OKAY);
            wr(AC1, {MODE_PULSE, 2'h1, e[0], 3'h0}, RESP_OKAY);
            drive_pin(1, 1'b1, 40);
            drive_pin(1, 1'b0, 80);
            drive_pin(1, 1'b1, 40);
            drive_pin(1, 1'b0, 10);
            rd(AD1, p - 8'h2, p + 8'h2, RESP_OKAY);
            rd(AC1, {MODE_PULSE, 2'h0, e[0], 3'h0}, {MODE_PULSE, 2'h0, e[0], 3'h0}, RESP_OKAY);
        end
        $display("test pulse width done");
        end_sim();
    end
endmodule : tb
bind det_timer_counter det_timer_counter_chk chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .event_pin(event_pin),
    .cnt0_overflow_flag(cnt0_overflow_flag), .cnt1_overflow_flag(cnt1_overflow_flag));
